/* File: shared/bit_word_pkg.sv */
package bit_word_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned clk_hz = 250_000_000;
  localparam int unsigned update_hz = 100;
  localparam int unsigned tick_cycles = clk_hz / update_hz;
  localparam int unsigned init_seconds = 60;
  localparam int unsigned init_ticks = init_seconds * update_hz;

  // ---------------------------------------------------------------
  // health word fields
  // ---------------------------------------------------------------
  localparam int fatal_pos = 0;
  localparam int hw_fault_pos = 1;
  localparam int link_fault_pos = 2;
  localparam int sw_fault_pos = 3;
  localparam int summary_pos = 8;
  localparam int hw_alert_pos = 9;
  localparam int link_alert_pos = 10;
  localparam int sw_alert_pos = 11;
  localparam int overrange_pos = 12;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] health_offset = 8'h00;
  localparam logic [7:0] alert_enable_offset = 8'h04;
  localparam logic [7:0] rate_select_offset = 8'h08;
  localparam logic [7:0] turn_threshold_offset = 8'h0c;
  localparam logic [7:0] get_packet_offset = 8'h10;
  localparam logic [7:0] packet_count_offset = 8'h14;
  localparam logic [7:0] diag_offset = 8'h18;

  // enable bits: 0 hw, 1 link, 2 sw, 3 overrange, 4 turn on sw alert
  localparam logic [4:0] alert_enable_reset = 5'h1e;
  localparam logic [2:0] rate_select_reset = 3'h2;
  localparam logic [15:0] turn_threshold_reset = 16'h0032;

  typedef enum logic [2:0] {
    rate_100, rate_50, rate_25, rate_20, rate_10, rate_5, rate_2, rate_quiet
  } rate_type;

  typedef struct packed {
    logic fatal;
    logic hw_fault;
    logic link_fault;
    logic sw_fault;
    logic heading_calib_out_of_bounds;
    logic calib_done;
    logic sat_fix;
    logic sat_link_ok;
    logic sat_time_valid;
    logic high_gain;
    logic overrange;
  } health_in_type;

  typedef struct packed {
    logic [15:0] health;
    logic valid;
    logic polled;
  } packet_out_type;

endpackage

/* File: rtl/builtin_test_status_word.sv */
`timescale 1ns/1ps

module builtin_test_status_word
  import bit_word_pkg::*;
#(
  parameter int unsigned tick_len = tick_cycles,
  parameter int unsigned init_len = init_ticks,
  parameter bit nav_variant = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // health inputs from the subsystems (asynchronous)
  input wire health_in_type health_in,
  input wire logic sat_pps,
  input wire logic [15:0] yaw_rate,
  // packet scheduling outputs
  output packet_out_type packet_out,
  output logic update_tick
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  health_in_type hin_meta;
  health_in_type hin;
  logic pps_meta;
  logic pps_sync;
  logic pps_last;
  logic [15:0] yaw_meta;
  logic [15:0] yaw;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hin_meta <= '0;
      hin <= '0;
      pps_meta <= 1'b0;
      pps_sync <= 1'b0;
      pps_last <= 1'b0;
      yaw_meta <= 16'h0000;
      yaw <= 16'h0000;
    end else if (clk_en) begin
      hin_meta <= health_in;
      hin <= hin_meta;
      pps_meta <= sat_pps;
      pps_sync <= pps_meta;
      pps_last <= pps_sync;
      yaw_meta <= yaw_rate;
      yaw <= yaw_meta;
    end
  end

  wire pps_rise = pps_sync & ~pps_last;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [4:0] alert_enable;
  logic [2:0] rate_select;
  logic [15:0] turn_threshold;
  logic [31:0] packet_count;
  logic fatal_latched;
  logic poll_pending;
  logic diag_pending;

  // ---------------------------------------------------------------
  // update tick and alignment
  // ---------------------------------------------------------------
  logic [31:0] tick_count;
  logic [31:0] init_count;
  logic [7:0] tick_index;
  logic init_busy;

  // re-phase the tick on the satellite second when time is valid
  wire align = pps_rise & hin.sat_time_valid;
  wire tick_now = align | (tick_count == 32'(tick_len - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_count <= 32'h00000000;
      tick_index <= 8'h00;
      init_count <= 32'h00000000;
      init_busy <= 1'b1;
    end else if (clk_en) begin
      tick_count <= tick_now ? 32'h00000000 : tick_count + 32'h00000001;
      if (align) begin
        tick_index <= 8'h00;
      end else if (tick_now) begin
        tick_index <= (tick_index == 8'(update_hz - 1)) ? 8'h00 : tick_index + 8'h01;
      end
      if (tick_now && init_busy) begin
        init_count <= init_count + 32'h00000001;
        init_busy <= (init_count != 32'(init_len - 1));
      end
    end
  end

  // ---------------------------------------------------------------
  // health word assembly
  // ---------------------------------------------------------------
  wire turning = alert_enable[4] & (yaw > turn_threshold);
  wire hw_alert = nav_variant ? ~hin.sat_fix : 1'b0;
  wire link_alert = ~hin.sat_link_ok;
  wire sw_alert = init_busy | hin.high_gain | turning;
  wire overrange_alert = hin.overrange;
  wire sw_fault = hin.sw_fault | hin.heading_calib_out_of_bounds | ~hin.calib_done;
  wire summary = (alert_enable[0] & hw_alert) | (alert_enable[1] & link_alert)
    | (alert_enable[2] & sw_alert) | (alert_enable[3] & overrange_alert);

  logic [15:0] next_health;
  always_comb begin
    next_health = 16'h0000;
    next_health[fatal_pos] = fatal_latched | hin.fatal;
    next_health[hw_fault_pos] = hin.hw_fault;
    next_health[link_fault_pos] = hin.link_fault;
    next_health[sw_fault_pos] = sw_fault;
    next_health[summary_pos] = summary;
    next_health[hw_alert_pos] = hw_alert;
    next_health[link_alert_pos] = link_alert;
    next_health[sw_alert_pos] = sw_alert;
    next_health[overrange_pos] = overrange_alert;
  end

  logic [15:0] health;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      health <= 16'h0000;
      fatal_latched <= 1'b0;
    end else if (clk_en) begin
      health <= next_health;
      fatal_latched <= fatal_latched | hin.fatal;
    end
  end

  // ---------------------------------------------------------------
  // packet scheduling
  // ---------------------------------------------------------------
  logic [7:0] divisor;
  always_comb begin
    case (rate_type'(rate_select))
      rate_100: divisor = 8'h01;
      rate_50: divisor = 8'h02;
      rate_25: divisor = 8'h04;
      rate_20: divisor = 8'h05;
      rate_10: divisor = 8'h0a;
      rate_5: divisor = 8'h14;
      rate_2: divisor = 8'h32;
      default: divisor = 8'h00;
    endcase
  end

  wire rate_hit = (divisor != 8'h00) && ((tick_index % divisor) == 8'h00);
  wire periodic = tick_now & rate_hit;
  wire poll_fire = tick_now & (poll_pending | diag_pending);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      packet_out <= '0;
      update_tick <= 1'b0;
      packet_count <= 32'h00000000;
    end else if (clk_en) begin
      update_tick <= tick_now;
      packet_out.valid <= periodic | poll_fire;
      packet_out.polled <= poll_fire & ~periodic;
      if (periodic | poll_fire) begin
        packet_out.health <= next_health;
        packet_count <= packet_count + 32'h00000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_alert = do_write && aw_addr == alert_enable_offset && w_strb[0];
  wire wr_rate = do_write && aw_addr == rate_select_offset && w_strb[0];
  wire wr_turn = do_write && aw_addr == turn_threshold_offset;
  wire wr_poll = do_write && aw_addr == get_packet_offset && w_strb[0];
  wire wr_known = wr_alert | wr_rate | wr_turn | wr_poll;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_enable <= alert_enable_reset;
      rate_select <= rate_select_reset;
      turn_threshold <= turn_threshold_reset;
      poll_pending <= 1'b0;
      diag_pending <= 1'b0;
    end else if (clk_en) begin
      if (wr_alert) begin
        alert_enable <= w_data[4:0];
      end
      if (wr_rate) begin
        rate_select <= w_data[2:0];
      end
      if (wr_turn) begin
        if (w_strb[0]) turn_threshold[7:0] <= w_data[7:0];
        if (w_strb[1]) turn_threshold[15:8] <= w_data[15:8];
      end
      // a new command wins over the clear at the firing tick
      poll_pending <= (wr_poll & w_data[0]) | (poll_pending & ~poll_fire);
      diag_pending <= (wr_poll & w_data[1]) | (diag_pending & ~poll_fire);
    end
  end

  logic [31:0] read_word;
  always_comb begin
    case (s_axi_araddr)
      health_offset: read_word = {16'h0000, health};
      alert_enable_offset: read_word = {27'h0000000, alert_enable};
      rate_select_offset: read_word = {29'h00000000, rate_select};
      turn_threshold_offset: read_word = {16'h0000, turn_threshold};
      get_packet_offset: read_word = {30'h00000000, diag_pending, poll_pending};
      packet_count_offset: read_word = packet_count;
      diag_offset: read_word = {21'h000000, hin};
      default: read_word = 32'h00000000;
    endcase
  end
  wire read_known = (s_axi_araddr <= diag_offset) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_known ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: bench/bit_word_checker_assertions.sv */
`timescale 1ns/1ps
module bit_word_checker
  import bit_word_pkg::*;
#(
  parameter int unsigned tick_len = tick_cycles
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // packets
  input wire packet_out_type packet_out,
  input wire logic update_tick
);
  logic [31:0] since_tick;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || update_tick) begin
      since_tick <= '0;
    end else if (clk_en) begin
      since_tick <= since_tick + 32'h1;
    end
  end
  a_tick_spacing: assert property (since_tick <= tick_len)
    else $error("update tick overdue");
  a_valid_cause: assert property (packet_out.valid |-> update_tick)
    else $error("packet without tick");
  a_valid_pulse: assert property (packet_out.valid |=> !packet_out.valid)
    else $error("packet valid longer than one cycle");
  a_reserved_zero: assert property (packet_out.valid |->
    packet_out.health[7:4] == 4'h0 && packet_out.health[15:13] == 3'h0)
    else $error("reserved health bits set");
  a_summary_cause: assert property (packet_out.valid && packet_out.health[8] |->
    |packet_out.health[12:9]) else $error("summary without alert");
  a_fatal_sticky: assert property (packet_out.health[0] |=> packet_out.health[0])
    else $error("fatal flag dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_addr_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  cover property (packet_out.valid && packet_out.polled);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (packet_out.valid && packet_out.health[0]);
endmodule

bind builtin_test_status_word bit_word_checker #(.tick_len(tick_len)) u_bit_word_checker (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .packet_out(packet_out),
  .update_tick(update_tick));

/* File: bench/packet_host.sv */
`timescale 1ns/1ps
module packet_host
  import bit_word_pkg::*;
(
  // clock and control
  input wire logic aclk,
  input wire logic clr,
  // packet stream
  input wire packet_out_type packet_out,
  // tallies
  output int unsigned pkt_cnt,
  output int unsigned poll_cnt,
  output logic [15:0] last_health
);
  // every packet brings its two-byte health word along
  always_ff @(posedge aclk) begin
    if (clr) begin
      pkt_cnt <= 0;
      poll_cnt <= 0;
    end else if (packet_out.valid) begin
      pkt_cnt <= pkt_cnt + 1;
      poll_cnt <= poll_cnt + (packet_out.polled ? 1 : 0);
      last_health <= packet_out.health;
    end
  end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import bit_word_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, clr = 1'b0, sat_pps = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_data, rdata;
  logic [15:0] yaw = 16'h0, last_health;
  health_in_type hin = 11'h038;
  logic awready, wready, bvalid, arready, rvalid, tick;
  logic [1:0] bresp, rresp, resp;
  packet_out_type pkt;
  int unsigned pkt_cnt, poll_cnt;
  int error_cnt = 0, checked = 0, n;
  logic [10:0] hv [9] = '{11'h038, 11'h238, 11'h138, 11'h0b8, 11'h078, 11'h018, 11'h030,
    11'h03a, 11'h039};
  logic [31:0] ex [9] = '{32'h0, 32'h2, 32'h4, 32'h8, 32'h8, 32'h8, 32'h500, 32'h900, 32'h1100};
  int unsigned nper [8] = '{100, 50, 25, 20, 10, 5, 2, 0};
  always #2 aclk = ~aclk;
  builtin_test_status_word #(.tick_len(50), .init_len(4), .nav_variant(1'b1))
    u_builtin_test_status_word (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .health_in(hin),
    .sat_pps(sat_pps), .yaw_rate(yaw), .packet_out(pkt), .update_tick(tick));
  packet_host u_packet_host (.aclk(aclk), .clr(clr), .packet_out(pkt), .pkt_cnt(pkt_cnt),
    .poll_cnt(poll_cnt), .last_health(last_health));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic over(input int k);
    if (k >= 100) begin
      chk("wait", 0, 1);
      conclude();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 100);
    resp = bresp;
    over(k);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 100);
    rd_data = rdata;
    resp = rresp;
    over(k);
  endtask
  task automatic tickwait();
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!tick && k < 100);
    over(k);
  endtask
  task automatic hchk(input logic [31:0] exp);
    cyc(60);
    rd(health_offset);
    chk("health", rd_data, exp);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(10);
    rd(health_offset);
    chk("init health", rd_data, 32'h0900);
    rd(alert_enable_offset);
    chk("alert enable", rd_data, 32'h1e);
    rd(rate_select_offset);
    chk("rate", rd_data, 32'h2);
    rd(turn_threshold_offset);
    chk("threshold", rd_data, 32'h32);
    rd(8'h1c);
    chk("unmapped", resp, 32'h2);
    wr(health_offset, 32'hffff);
    chk("read only", resp, 32'h2);
    cyc(260);
    for (int i = 0; i < 9; i++) begin
      hin <= hv[i];
      hchk(ex[i]);
    end
    hin <= 11'h038;
    yaw <= 16'h0033;
    hchk(32'h0900);
    yaw <= 16'h0032;
    hchk(32'h0);
    yaw <= 16'h0033;
    wr(alert_enable_offset, 32'h0e);
    hchk(32'h0);
    wr(alert_enable_offset, 32'h1f);
    hin <= 11'h028;
    yaw <= 16'h0000;
    hchk(32'h0300);
    wr(alert_enable_offset, 32'h17);
    hin <= 11'h039;
    cyc(60);
    rd(health_offset);
    chk("summary", rd_data & 32'h100, 32'h0);
    hin <= 11'h03c;
    for (int c = 0; c < 8; c++) begin
      wr(rate_select_offset, c);
      tickwait();
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      cyc(5000);
      chk("packets", pkt_cnt, nper[c]);
    end
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    rd(packet_count_offset);
    n = rd_data;
    wr(get_packet_offset, 32'h3);
    cyc(120);
    chk("polled", poll_cnt, 1);
    chk("quiet", pkt_cnt, 1);
    rd(packet_count_offset);
    chk("count", rd_data - n, 1);
    rd(get_packet_offset);
    chk("pending", rd_data, 0);
    rd(health_offset);
    chk("packet word", last_health, 16'h0000);
    chk("reg word", rd_data, 32'h0);
    rd(diag_offset);
    chk("diag", rd_data, 32'h03c);
    tickwait();
    cyc(20);
    sat_pps <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!tick && n < 12);
    sat_pps <= 1'b0;
    chk("aligned tick", n < 12, 1);
    tickwait();
    clk_en <= 1'b0;
    n = 0;
    repeat (120) begin
      @(posedge aclk);
      n += tick;
    end
    clk_en <= 1'b1;
    chk("frozen tick", n, 0);
    hin <= 11'h438;
    cyc(10);
    hin <= 11'h03c;
    wr(get_packet_offset, 32'h1);
    hchk(32'h0001);
    cyc(60);
    conclude();
  end
endmodule
